// [rtl/sfc_defs.svh]
// Register indices, reset values and bit positions of the SPI FIFO config block.
// Assumes inclusion by bare name; definitions only.
// Operation
// - Interrupt after one to four bytes transferred
// - Two-bit field selects interrupt byte count
// - Flush bit clears both FIFOs
// - Rate codes 0-3 divide by 4,6,8,16
// - Code 100 divides by 2, 101 by 32
// - Code 110 divides by 128, 111 by 256
// - Bit order one MSB first, zero LSB
// - Configuration resets with only flush bit set
// - Transfer done flag set after the selected byte count is transferred
// - Full receive FIFO plus new byte sets overrun, unless a byte is read out in the same cycle
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
`define SFC_IDX_CFG 8'ha1
`define SFC_IDX_STAT 8'ha3
`define SFC_IDX_DATA 8'ha4
`define SFC_IDX_MASK 8'ha5
`define SFC_CFG_RESET 8'h20
`define SFC_CFG_WMASK 8'hef
`define SFC_ST_DONE 7
`define SFC_ST_RX_OVERRUN_FLAG 6
`define SFC_ST_TOVR 5
`define SFC_ST_RFULL 3
`define SFC_ST_REMPT 2
`define SFC_ST_TFULL 1
`define SFC_ST_TEMPT 0
`define SFC_STICKY_MASK 8'he0
`endif

// [rtl/sfc_pkg.sv]
// Types shared by the SPI FIFO config block.
// Assumes the constants header is compiled alongside.
package sfc_pkg;
  // Configuration register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] irqThreshold;
    logic fifoFlush;
    logic unused;
    logic [2:0] sckRateSelect;
    logic msbFirst;
  } sfc_cfg_t;
  typedef enum logic {SFC_IDLE, SFC_SHIFT} sfc_state_t;
  // Serial pins of the master engine
  typedef struct packed {
    logic sck;
    logic mosi;
    logic ssN;
  } sfc_pins_t;
endpackage : sfc_pkg

// [rtl/sfc_spi_fifo_config.sv]
// SPI master with transmit/receive FIFOs, configuration, status, mask and irq.
// Assumes a classic Wishbone master on core_clk and one external SPI slave.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_spi_fifo_config
  import sfc_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic miso,
  output sfc_pins_t spiPins,
  output logic irq
);
  // Half period of SCK in core clocks for each rate code
  function automatic logic [7:0] halfPeriod(input logic [2:0] code);
    case (code)
      3'd0: halfPeriod = 8'h02;
      3'd1: halfPeriod = 8'h03;
      3'd2: halfPeriod = 8'h04;
      3'd3: halfPeriod = 8'h08;
      3'd4: halfPeriod = 8'h01;
      3'd5: halfPeriod = 8'h10;
      3'd6: halfPeriod = 8'h40;
      default: halfPeriod = 8'h80;
    endcase
  endfunction : halfPeriod

  // FIFO storage; DEPTH must be a power of two, at least four
  logic [7:0] txMem [DEPTH];
  logic [7:0] rxMem [DEPTH];

  sfc_cfg_t cfg_reg, cfg_next;
  logic [2:0] sticky_reg, sticky_next;
  logic [7:0] mask_reg, mask_next;
  logic [AW-1:0] txWr_reg, txWr_next, txRd_reg, txRd_next;
  logic [AW-1:0] rxWr_reg, rxWr_next, rxRd_reg, rxRd_next;
  logic [AW:0] txCnt_reg, txCnt_next, rxCnt_reg, rxCnt_next;
  sfc_state_t state_reg, state_next;
  logic [7:0] div_reg, div_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bytes_reg, bytes_next;
  sfc_pins_t pins_reg, pins_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic txPush, rxPush;

  logic req, wrDo, rdDo;
  logic [7:0] idx, wByte, status;
  logic txFull, rxFull, txEmpty, rxEmpty;

  // Bus decode; writes and pops act only on the acknowledged edge
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[9:2];
  assign wrDo = req & ack_reg & wb_we_i & wb_sel_i[0];
  assign rdDo = req & ack_reg & ~wb_we_i;
  assign wByte = wb_dat_i[7:0];
  assign txFull = txCnt_reg == (AW+1)'(DEPTH);
  assign rxFull = rxCnt_reg == (AW+1)'(DEPTH);
  assign txEmpty = txCnt_reg == '0;
  assign rxEmpty = rxCnt_reg == '0;

  // Status image: sticky flags on top, live FIFO levels below
  always_comb begin
    status = {sticky_reg, 1'b0, rxFull, rxEmpty, txFull, txEmpty};
  end

  // Level interrupt from unmasked sticky flags
  assign irq = |(status & mask_reg & `SFC_STICKY_MASK);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign spiPins = pins_reg;

  // Next-state logic for bus, FIFOs and serial engine
  always_comb begin
    logic flushNow;
    logic doneEv, rovrEv, tovrEv;
    logic txPop, rxPop;
    logic [7:0] half, rdVal;
    flushNow = 1'b0;
    doneEv = 1'b0;
    rovrEv = 1'b0;
    tovrEv = 1'b0;
    txPop = 1'b0;
    rxPop = 1'b0;
    txPush = 1'b0;
    rxPush = 1'b0;
    half = halfPeriod(cfg_reg.sckRateSelect);
    rdVal = 8'h00;
    cfg_next = cfg_reg;
    sticky_next = sticky_reg;
    mask_next = mask_reg;
    state_next = state_reg;
    div_next = div_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    bytes_next = bytes_reg;
    pins_next = pins_reg;
    ack_next = req & ~ack_reg;
    dat_next = dat_reg;

    // Read data is formed while waiting, so it is valid with ack
    case (idx)
      `SFC_IDX_CFG: rdVal = cfg_reg & `SFC_CFG_WMASK;
      `SFC_IDX_STAT: rdVal = status;
      `SFC_IDX_DATA: rdVal = rxEmpty ? 8'h00 : rxMem[rxRd_reg];
      `SFC_IDX_MASK: rdVal = mask_reg;
      default: rdVal = 8'h00;
    endcase
    if (req & ~ack_reg) begin
      dat_next = {24'h00_0000, rdVal};
    end

    // Register writes
    if (wrDo) begin
      case (idx)
        `SFC_IDX_CFG: begin
          cfg_next = wByte & `SFC_CFG_WMASK;
          flushNow = wByte[5];
        end
        `SFC_IDX_STAT: sticky_next = sticky_reg & ~wByte[7:5];
        `SFC_IDX_DATA: begin
          if (txFull) begin
            tovrEv = 1'b1;
          end else begin
            txPush = 1'b1;
          end
        end
        `SFC_IDX_MASK: mask_next = wByte & `SFC_STICKY_MASK;
        default: ;
      endcase
    end
    if (rdDo && idx == `SFC_IDX_DATA && !rxEmpty) begin
      rxPop = 1'b1;
    end

    // Serial engine, mode 0: sample on rising SCK, drive on falling
    case (state_reg)
      SFC_IDLE: begin
        pins_next.sck = 1'b0;
        pins_next.ssN = 1'b1;
        if (!txEmpty && !flushNow) begin
          txPop = 1'b1;
          shift_next = txMem[txRd_reg];
          pins_next.mosi = cfg_reg.msbFirst ? txMem[txRd_reg][7]
                                            : txMem[txRd_reg][0];
          pins_next.ssN = 1'b0;
          div_next = 8'h00;
          bit_next = 3'd0;
          state_next = SFC_SHIFT;
        end
      end
      SFC_SHIFT: begin
        div_next = div_reg + 8'h01;
        if (div_reg == half - 8'h01) begin
          div_next = 8'h00;
          if (!pins_reg.sck) begin
            pins_next.sck = 1'b1;
            shift_next = cfg_reg.msbFirst ? {shift_reg[6:0], miso}
                                          : {miso, shift_reg[7:1]};
          end else begin
            pins_next.sck = 1'b0;
            pins_next.mosi = cfg_reg.msbFirst ? shift_reg[7] : shift_reg[0];
            if (bit_reg == 3'd7) begin
              state_next = SFC_IDLE;
              pins_next.ssN = 1'b1;
              if (rxFull && !rxPop) begin
                rovrEv = 1'b1;
              end else begin
                rxPush = 1'b1;
              end
              // Count bytes and fire once the threshold is met
              if (bytes_reg == {1'b0, cfg_reg.irqThreshold}) begin
                doneEv = 1'b1;
                bytes_next = 3'd0;
              end else begin
                bytes_next = bytes_reg + 3'd1;
              end
            end else begin
              bit_next = bit_reg + 3'd1;
            end
          end
        end
      end
      default: state_next = SFC_IDLE;
    endcase

    // Events set after the clear so a coincident set wins
    if (doneEv) begin
      sticky_next[`SFC_ST_DONE-5] = 1'b1;
    end
    if (rovrEv) begin
      sticky_next[`SFC_ST_RX_OVERRUN_FLAG-5] = 1'b1;
    end
    if (tovrEv) begin
      sticky_next[`SFC_ST_TOVR-5] = 1'b1;
    end

    // FIFO pointers; flush drops contents and the byte tally
    txWr_next = txWr_reg + AW'(txPush);
    txRd_next = txRd_reg + AW'(txPop);
    txCnt_next = txCnt_reg + (AW+1)'(txPush) - (AW+1)'(txPop);
    rxWr_next = rxWr_reg + AW'(rxPush);
    rxRd_next = rxRd_reg + AW'(rxPop);
    rxCnt_next = rxCnt_reg + (AW+1)'(rxPush) - (AW+1)'(rxPop);
    if (flushNow) begin
      txWr_next = '0;
      txRd_next = '0;
      txCnt_next = '0;
      rxWr_next = '0;
      rxRd_next = '0;
      rxCnt_next = '0;
      bytes_next = 3'd0;
    end
  end

  // FIFO storage writes; contents need no reset
  always_ff @(posedge core_clk) begin
    if (txPush) begin
      txMem[txWr_reg] <= wByte;
    end
    if (rxPush) begin
      rxMem[rxWr_reg] <= shift_reg;
    end
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_reg <= `SFC_CFG_RESET;
      sticky_reg <= 3'd0;
      mask_reg <= 8'h00;
      txWr_reg <= '0;
      txRd_reg <= '0;
      txCnt_reg <= '0;
      rxWr_reg <= '0;
      rxRd_reg <= '0;
      rxCnt_reg <= '0;
      state_reg <= SFC_IDLE;
      div_reg <= 8'h00;
      bit_reg <= 3'd0;
      shift_reg <= 8'h00;
      bytes_reg <= 3'd0;
      pins_reg <= 3'b001;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      sticky_reg <= sticky_next;
      mask_reg <= mask_next;
      txWr_reg <= txWr_next;
      txRd_reg <= txRd_next;
      txCnt_reg <= txCnt_next;
      rxWr_reg <= rxWr_next;
      rxRd_reg <= rxRd_next;
      rxCnt_reg <= rxCnt_next;
      state_reg <= state_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      bytes_reg <= bytes_next;
      pins_reg <= pins_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end
endmodule : sfc_spi_fifo_config
`default_nettype wire

// [test/sfc_checker.sv]
// Checker for the SPI config block: bus, frame timing, irq.
// Bound to sfc_spi_fifo_config, sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sfc_checker
  import sfc_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic miso,
  input wire sfc_pins_t spiPins,
  input wire logic irq
);
  localparam int DIV[8] = '{4, 6, 8, 16, 2, 32, 128, 256};
  logic [7:0] cfg_reg, cfg_next, mask_reg, mask_next;
  logic [15:0] cnt_reg, cnt_next;
  logic sck_reg, ss_reg, wr;
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  // Shadows follow writes at the ack edge; counter times pin changes
  always_comb begin
    cfg_next = (wr && wb_adr_i[9:2] == 8'ha1) ? wb_dat_i[7:0] : cfg_reg;
    mask_next = (wr && wb_adr_i[9:2] == 8'ha5) ? wb_dat_i[7:0] : mask_reg;
    cnt_next = (spiPins.sck != sck_reg || spiPins.ssN != ss_reg) ? 16'h0001 : cnt_reg + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    cfg_reg <= srst ? 8'h20 : cfg_next;
    mask_reg <= srst ? 8'h00 : mask_next;
    cnt_reg <= srst ? 16'h0000 : cnt_next;
    sck_reg <= srst ? 1'b0 : spiPins.sck;
    ss_reg <= srst ? 1'b1 : spiPins.ssN;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("late ack");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_cfg_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'ha1
    |-> wb_dat_o[7:0] == (cfg_reg & 8'hef)) else $error("config readback");
  a_irq_masked: assert property (mask_reg[7:5] == 3'b000 |-> !irq) else $error("irq unmasked");
  a_sck_idle: assert property (spiPins.ssN |-> !spiPins.sck) else $error("sck outside frame");
  a_half_period: assert property (spiPins.sck != sck_reg |-> cnt_reg == DIV[cfg_reg[3:1]] / 2)
    else $error("wrong sck half period");
  a_frame_hold: assert property ($fell(spiPins.ssN) |-> !spiPins.ssN [*8])
    else $error("short frame");
  // Gap between bytes may be one cycle; sck must stay low across it
  a_frame_gap: assert property ($rose(spiPins.ssN) |-> !spiPins.sck ##1 !spiPins.sck)
    else $error("sck moved in gap");
  c_frame: cover property ($fell(spiPins.ssN));
  c_irq: cover property ($rose(irq));
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : sfc_checker
bind sfc_spi_fifo_config sfc_checker chk_u (.core_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .miso, .spiPins, .irq);
`default_nettype wire

// [test/sfc_slave_model.sv]
// Serial slave model: samples mosi on sck rise, answers a fixed byte.
// Assumes mode 0 framing with ssN low across each byte.
`timescale 1ns/1ps
`default_nettype none
module sfc_slave_model #(
  parameter logic [7:0] REPLY = 8'h3a
) (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ssN,
  input wire logic msbFirst,
  output logic miso,
  output logic [7:0] rxByte
);
  // Model only answers; it never drives sck, which the master alone generates
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    rxByte = 8'h00;
  end
  // Reply shifts out on falling sck in the chosen order
  always @(negedge ssN) begin
    sh = REPLY;
    miso = msbFirst ? sh[7] : sh[0];
  end
  always @(negedge sck) if (!ssN) begin
    sh = msbFirst ? sh << 1 : sh >> 1;
    miso = msbFirst ? sh[7] : sh[0];
  end
  // Released line must not keep its last value
  always @(posedge ssN) miso = ~miso;
  always @(posedge sck) rxByte = msbFirst ? {rxByte[6:0], mosi} : {mosi, rxByte[7:1]};
endmodule : sfc_slave_model
`default_nettype wire

// [test/spi_fifo_config_control_test.sv]
// Bench: Wishbone register sequences against the block and a slave model.
// Assumes a one-cycle bus answer and a 10 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module spi_fifo_config_control_test
  import sfc_pkg::*;
;
  logic core_clk, srst, req, we, ack, miso, irq, msb;
  logic [9:0] adr;
  logic [31:0] dat, rdat, s;
  logic [7:0] rxByte, b;
  sfc_pins_t pins;
  int errCount, checksDone;
  sfc_spi_fifo_config dut_u (.core_clk(core_clk), .srst(srst), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1), .wb_dat_o(rdat),
    .wb_ack_o(ack), .miso(miso), .spiPins(pins), .irq(irq));
  sfc_slave_model peer_u (.sck(pins.sck), .mosi(pins.mosi), .ssN(pins.ssN), .msbFirst(msb),
    .miso(miso), .rxByte(rxByte));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("Errors %0d, checks %0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic bail;
    errCount++;
    $display("CHECK FAILED at %0t: timeout", $time);
    report_and_stop();
  endtask : bail
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One classic cycle; read data kept in s
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 10);
    s = rdat;
    req <= 1'b0;
    if (n >= 10) bail();
  endtask : wb
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(s, e);
  endtask : rd
  // Poll until the tx queue is empty and no frame runs
  task automatic idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, 10'h28c, 8'h00);
      n++;
    end while (!(s[0] === 1'b1 && pins.ssN === 1'b1) && n < 4000);
    if (n >= 4000) bail();
  endtask : idle
  initial begin
    srst = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    dat = 32'h0000_0000;
    msb = 1'b1;
    errCount = 0;
    checksDone = 0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rd(10'h284, 32'h0000_0020);
    rd(10'h28c, 32'h0000_0005);
    rd(10'h3fc, 32'h0000_0000);
    wb(1'b1, 10'h284, 8'hff);
    rd(10'h284, 32'h0000_00ef);
    wb(1'b1, 10'h294, 8'h80);
    // Every rate code, alternating bit order
    for (int c = 0; c < 8; c++) begin
      b = 8'h1d ^ c[7:0];
      msb <= c[0];
      wb(1'b1, 10'h284, {4'h0, c[2:0], c[0]});
      wb(1'b1, 10'h290, b);
      idle();
      chk({24'h00_0000, rxByte}, {24'h00_0000, b});
      rd(10'h28c, 32'h0000_0081);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(10'h290, 32'h0000_003a);
      wb(1'b1, 10'h28c, 8'h80);
      @(negedge core_clk);
      chk({31'h0, irq}, 32'h0000_0000);
    end
    // Four-byte threshold, full receive queue, overrun, flush
    wb(1'b1, 10'h294, 8'h00);
    msb <= 1'b1;
    wb(1'b1, 10'h284, 8'hc1);
    for (int i = 0; i < 3; i++) wb(1'b1, 10'h290, 8'h60 + i[7:0]);
    idle();
    rd(10'h28c, 32'h0000_0001);
    wb(1'b1, 10'h290, 8'h71);
    idle();
    rd(10'h28c, 32'h0000_0089);
    wb(1'b1, 10'h290, 8'h72);
    idle();
    rd(10'h28c, 32'h0000_00c9);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(1'b1, 10'h294, 8'h40);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wb(1'b1, 10'h28c, 8'hc0);
    wb(1'b1, 10'h284, 8'he1);
    rd(10'h28c, 32'h0000_0005);
    chk({31'h0, irq}, 32'h0000_0000);
    report_and_stop();
  end
endmodule : spi_fifo_config_control_test
`default_nettype wire
